/* pkg/lia_regs.vh */
// constants for the line imager acquisition and read-out sequencer
`ifndef LIA_REGS_VH
`define LIA_REGS_VH
`define LIA_CLK_MHZ 250
`define LIA_FLUSH_NS 200
`define LIA_SHIFT_NS 100
`define LIA_SAMPLE_NS 400
`define LIA_RDPULSE_NS 100
`define LIA_HOLD_NS 2000
`define LIA_CLEAR_NS 200
`define LIA_WAKE_NS 1000
`define LIA_NS2CYC(ns) (((ns) * `LIA_CLK_MHZ + 999) / 1000)
`define LIA_NS2CYC_DN(ns) (((ns) * `LIA_CLK_MHZ) / 1000)
`define LIA_SLOTS 4
`define LIA_PRELOAD 3
`define LIA_ADR_CTRL 4'h0
`define LIA_ADR_STAT 4'h4
`define LIA_ADR_CONF 4'h8
`define LIA_ADR_ID 4'hc
// identity value is arbitrary, names no real part
`define LIA_ID_VALUE 32'h0000a5c3
`endif

/* src/lia_ctrl.v */
// acquisition and read-out sequencer of a line imager
//
// The Wishbone slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "lia_regs.vh"
module lia_ctrl (
  // clock and reset
  input wire CLOCK,
  input wire RESET,
  // controller pins
  input wire EXPOSE_GATE_IN,
  input wire READ_IN,
  input wire PIXEL_FLUSH_IN,
  input wire FRAME_CLEAR_IN,
  input wire POWER_DOWN_IN,
  input wire CENTRE_REGION_SELECT,
  input wire [1:0] BIN_FACTOR_SELECT,
  // status pins
  output reg FRAME_READY,
  output reg LAST_PIXEL_FLAG,
  output reg PIXEL_VALID,
  output reg [10:0] PIXEL_INDEX,
  output reg VIDEO_HOLD,
  output reg POWERED_DOWN,
  // wishbone slave
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [3:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK_O
);
  localparam [15:0] FLUSH_C = `LIA_NS2CYC(`LIA_FLUSH_NS);
  localparam [15:0] SHIFT_C = `LIA_NS2CYC(`LIA_SHIFT_NS);
  localparam [15:0] SAMPLE_C = `LIA_NS2CYC(`LIA_SAMPLE_NS);
  localparam [15:0] RDPULSE_C = `LIA_NS2CYC(`LIA_RDPULSE_NS);
  localparam [15:0] HOLD_C = `LIA_NS2CYC_DN(`LIA_HOLD_NS);
  localparam [15:0] WAKE_C = `LIA_NS2CYC(`LIA_WAKE_NS);
  localparam [2:0] SLOTS = `LIA_SLOTS;
  localparam [10:0] PRELOAD = `LIA_PRELOAD;
  // acquisition states
  localparam [5:0] A_IDLE = 6'h01;
  localparam [5:0] A_FLUSH = 6'h02;
  localparam [5:0] A_EXPOSE = 6'h04;
  localparam [5:0] A_SHIFT = 6'h08;
  localparam [5:0] A_PFLUSH = 6'h10;
  localparam [5:0] A_DOWN = 6'h20;
  // read-out states
  localparam [3:0] R_IDLE = 4'h1;
  localparam [3:0] R_SAMPLE = 4'h2;
  localparam [3:0] R_CLOCK = 4'h4;
  localparam [3:0] R_HOLD = 4'h8;

  // timing at the pins, in clock cycles of this block
  // every controller pin input passes two flops, so edges act two or three cycles late
  // exposure gate rise in idle: flush, then exposure runs while gate stays high
  // exposure gate fall: shift into the store, then the frame count goes up
  // frame-ready follows the frame count one cycle later
  // read pulse: recognised on its fall, only if it stood long enough
  // a short high on the read pin is a read clock, never a read pulse
  // sampling runs a fixed span after the pulse; clocks in that span are lost
  // the first three clocks after sampling only fill the output pipeline
  // each later clock gives one pixel strobe with its index
  // the final clock raises the last-pixel flag and starts the video hold
  // the flag stays up until the next rising edge on the read pin
  // the video hold ends after its span or at the next accepted read pulse
  //
  // frame store bookkeeping
  // the count holds frames captured and not yet taken by a read pulse
  // a read pulse takes the oldest frame at once, so the count drops early
  // frame-ready must not follow that early drop for the last frame:
  // it stays up until the first read clock of that frame
  // a capture that ends in the cycle of a read pulse sees the lowered count
  // so a full store frees a slot as soon as the read pulse is taken
  // the compaction flag marks that the latest frame was stored while at least one other frame was held
  //
  // flush and clear
  // a pixel flush edge opens a window in which exposures are refused
  // pixel flush edges are only seen in idle with the gate low,
  // so they are lost while exposing or shifting
  // a frame clear edge in idle empties the store and runs a field flush
  // a clear together with a gate rise runs the exposure flush instead
  // a clear during a shift is lost; the controller must avoid it
  // a clear edge in idle aborts a read-out still in sampling
  // a frame already sampled may still be clocked out after a clear
  //
  // power-down
  // only entered with read-out idle, so a running frame is finished first
  // stored frames are dropped on entry
  // leaving it runs the wake flush before any exposure is accepted
  // reset lands in the same wake flush, so the down indication is high from the start
  //
  // region and binning
  // the pins are resampled at each accepted read pulse
  // the configuration register shows the count for the pins as they stand now
  // binning codes: 0 halves, 2 quarters, 1 and 3 read every pixel
  //
  // register port
  // a request is answered one cycle after it is seen, without wait states
  // the answer stands one cycle; a held request is answered again every second cycle
  // only the control bit is writable; other writes are dropped
  // the software hold-off bit only forces the down indication
  // it does not stop the sequencer, which keeps its own state
  //
  // limitation: the counters are 16 bits wide, ample for the chosen spans
  // limitation: read clocks beyond the frame's count are ignored in hold

  reg [4:0] s1_q;
  reg [4:0] s2_q;
  reg [4:0] s3_q;
  reg [1:0] bs1_q;
  reg [1:0] bs2_q;
  reg rs1_q;
  reg rs2_q;
  always @(posedge CLOCK) begin
    if (RESET) begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
      s3_q <= 5'h00;
      bs1_q <= 2'h0;
      bs2_q <= 2'h0;
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      s1_q <= {POWER_DOWN_IN, FRAME_CLEAR_IN, PIXEL_FLUSH_IN, READ_IN, EXPOSE_GATE_IN};
      s2_q <= s1_q;
      s3_q <= s2_q;
      bs1_q <= BIN_FACTOR_SELECT;
      bs2_q <= bs1_q;
      rs1_q <= CENTRE_REGION_SELECT;
      rs2_q <= rs1_q;
    end
  end
  wire gate = s2_q[0];
  wire rd = s2_q[1];
  wire clr = s2_q[3];
  wire pdn = s2_q[4];
  wire gate_rise = s2_q[0] & ~s3_q[0];
  wire gate_fall = ~s2_q[0] & s3_q[0];
  wire rd_rise = s2_q[1] & ~s3_q[1];
  wire rd_fall = ~s2_q[1] & s3_q[1];
  wire pf_rise = s2_q[2] & ~s3_q[2];
  wire clr_rise = s2_q[3] & ~s3_q[3];

  reg [5:0] ast_q;
  reg [15:0] acnt_q;
  reg [2:0] nfr_q;
  reg compact_q;
  reg [15:0] pfwin_q;
  reg [3:0] rst_q;
  reg [15:0] rcnt_q;
  reg [15:0] rpw_q;
  reg [10:0] clk_q;
  reg [10:0] total_q;
  reg rd_own_q;
  reg ctl_q;
  reg frame_rd_q;
  reg rd_take;

  function [10:0] clocks_for;
    input roi;
    input [1:0] bin;
    reg [10:0] px;
    begin
      px = roi ? 11'd512 : 11'd1024;
      case (bin)
        2'd0: px = px >> 1;
        2'd2: px = px >> 2;
        default: px = px;
      endcase
      clocks_for = px + PRELOAD;
    end
  endfunction

  wire busy_rd = (rst_q != R_IDLE);
  always @(posedge CLOCK) begin
    if (RESET) begin
      ast_q <= A_DOWN;
      // reset runs the wake flush too
      acnt_q <= WAKE_C;
      nfr_q <= 3'd0;
      compact_q <= 1'b0;
      pfwin_q <= 16'h0000;
    end else begin
      if (pfwin_q != 16'h0000) pfwin_q <= pfwin_q - 16'h0001;
      if (rd_take) nfr_q <= nfr_q - 3'd1;
      case (ast_q)
        A_IDLE: begin
          if (clr_rise) begin
            nfr_q <= 3'd0;
            compact_q <= 1'b0;
            ast_q <= A_PFLUSH;
            acnt_q <= FLUSH_C;
            if (gate_rise) begin
              ast_q <= A_FLUSH;
            end
          end else if (pdn && !busy_rd) begin
            ast_q <= A_DOWN;
            nfr_q <= 3'd0;
            compact_q <= 1'b0;
          end else if (gate_rise && pfwin_q == 16'h0000 && (nfr_q - (rd_take ? 3'd1 : 3'd0)) < SLOTS) begin
            ast_q <= A_FLUSH;
            acnt_q <= FLUSH_C;
          end else if (pf_rise && !gate) begin
            pfwin_q <= FLUSH_C;
            ast_q <= A_PFLUSH;
            acnt_q <= FLUSH_C;
          end
        end
        A_FLUSH, A_PFLUSH: begin
          if (acnt_q > 16'h0001) begin
            acnt_q <= acnt_q - 16'h0001;
          end else if (ast_q == A_FLUSH) begin
            ast_q <= A_EXPOSE;
          end else begin
            ast_q <= A_IDLE;
          end
        end
        A_EXPOSE: begin
          if (gate_fall || !gate) begin
            ast_q <= A_SHIFT;
            acnt_q <= SHIFT_C;
          end
        end
        A_SHIFT: begin
          if (acnt_q > 16'h0001) begin
            acnt_q <= acnt_q - 16'h0001;
          end else begin
            compact_q <= (nfr_q - (rd_take ? 3'd1 : 3'd0)) != 3'd0;
            nfr_q <= nfr_q - (rd_take ? 3'd1 : 3'd0) + 3'd1;
            ast_q <= A_IDLE;
          end
        end
        A_DOWN: begin
          nfr_q <= 3'd0;
          if (pdn) begin
            acnt_q <= WAKE_C;
          end else if (acnt_q > 16'h0001) begin
            acnt_q <= acnt_q - 16'h0001;
          end else begin
            ast_q <= A_IDLE;
          end
        end
        default: ast_q <= A_IDLE;
      endcase
    end
  end

  // read pulse recognised on its falling edge once wide enough
  wire rd_pulse = rd_fall && rpw_q >= RDPULSE_C;
  always @* begin
    rd_take = 1'b0;
    if (rd_pulse && nfr_q != 3'd0 && ast_q != A_DOWN && !clr_rise) rd_take = 1'b1;
  end

  always @(posedge CLOCK) begin
    if (RESET) begin
      rst_q <= R_IDLE;
      rcnt_q <= 16'h0000;
      rpw_q <= 16'h0000;
      clk_q <= 11'd0;
      total_q <= 11'd0;
      rd_own_q <= 1'b0;
      frame_rd_q <= 1'b0;
      FRAME_READY <= 1'b0;
      LAST_PIXEL_FLAG <= 1'b0;
      PIXEL_VALID <= 1'b0;
      PIXEL_INDEX <= 11'd0;
      VIDEO_HOLD <= 1'b0;
    end else begin
      rpw_q <= rd ? ((rpw_q == 16'hffff) ? rpw_q : rpw_q + 16'h0001) : 16'h0000;
      PIXEL_VALID <= 1'b0;
      // flag falls on next read edge
      if (rd_rise) LAST_PIXEL_FLAG <= 1'b0;
      if (nfr_q != 3'd0 && !(rd_own_q && nfr_q == 3'd1)) FRAME_READY <= 1'b1;
      // last frame keeps ready until its first clock
      if (nfr_q == 3'd0 && !(rd_own_q && clk_q == 11'd0)) FRAME_READY <= 1'b0;
      if (ast_q == A_IDLE && clr_rise) FRAME_READY <= 1'b0;
      if (rd_take) begin
        rst_q <= R_SAMPLE;
        rcnt_q <= SAMPLE_C;
        rd_own_q <= 1'b1;
        frame_rd_q <= 1'b1;
        VIDEO_HOLD <= 1'b0;
        clk_q <= 11'd0;
        total_q <= clocks_for(rs2_q, bs2_q);
      end else if (ast_q == A_IDLE && clr_rise && rst_q == R_SAMPLE) begin
        rst_q <= R_IDLE;
        rd_own_q <= 1'b0;
      end else begin
        case (rst_q)
          R_IDLE: rd_own_q <= 1'b0;
          R_SAMPLE: begin
            if (rcnt_q > 16'h0001) rcnt_q <= rcnt_q - 16'h0001;
            else rst_q <= R_CLOCK;
          end
          R_CLOCK: begin
            if (rd_rise) begin
              if (clk_q == 11'd0 && nfr_q == 3'd0) FRAME_READY <= 1'b0;
              clk_q <= clk_q + 11'd1;
              if (clk_q >= PRELOAD) begin
                PIXEL_VALID <= 1'b1;
                PIXEL_INDEX <= clk_q - PRELOAD;
              end
              if (clk_q + 11'd1 == total_q) begin
                LAST_PIXEL_FLAG <= 1'b1;
                rst_q <= R_HOLD;
                rcnt_q <= HOLD_C;
                rd_own_q <= 1'b0;
              end
            end
          end
          R_HOLD: begin
            VIDEO_HOLD <= 1'b1;
            if (rcnt_q > 16'h0001) begin
              rcnt_q <= rcnt_q - 16'h0001;
            end else begin
              VIDEO_HOLD <= 1'b0;
              rst_q <= R_IDLE;
              frame_rd_q <= 1'b0;
            end
          end
          default: rst_q <= R_IDLE;
        endcase
      end
    end
  end

  // wishbone slave: one wait-free ack cycle
  reg [31:0] rdat;
  always @* begin
    rdat = 32'h00000000;
    case (WB_ADR_I)
      `LIA_ADR_CTRL: rdat = {31'h0, ctl_q};
      `LIA_ADR_STAT: rdat = {16'h0, rst_q, ast_q, compact_q, nfr_q, FRAME_READY, LAST_PIXEL_FLAG};
      `LIA_ADR_CONF: rdat = {21'h0, clocks_for(rs2_q, bs2_q)};
      `LIA_ADR_ID: rdat = `LIA_ID_VALUE;
      default: rdat = 32'h00000000;
    endcase
  end
  always @(posedge CLOCK) begin
    if (RESET) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
      ctl_q <= 1'b0;
      POWERED_DOWN <= 1'b1;
    end else begin
      WB_ACK_O <= WB_CYC_I && WB_STB_I && !WB_ACK_O;
      if (WB_CYC_I && WB_STB_I && !WB_ACK_O) begin
        WB_DAT_O <= rdat;
        if (WB_WE_I && WB_ADR_I == `LIA_ADR_CTRL && WB_SEL_I[0]) ctl_q <= WB_DAT_I[0];
      end
      // software hold-off forces the down indication
      POWERED_DOWN <= (ast_q == A_DOWN) | ctl_q;
    end
  end
endmodule

/* verif/lia_ctrl_assertions.sv */
// port checker for the line imager sequencer
`timescale 1ns/1ps
module lia_chk (
  // clock and reset
  input wire CLOCK,
  input wire RESET,
  // watched pins
  input wire EXPOSE_GATE_IN,
  input wire READ_IN,
  input wire FRAME_CLEAR_IN,
  input wire FRAME_READY,
  input wire LAST_PIXEL_FLAG,
  input wire PIXEL_VALID,
  input wire [10:0] PIXEL_INDEX,
  input wire VIDEO_HOLD,
  input wire POWERED_DOWN,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_ACK_O
);
  logic [9:0] hold_q;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  // hold length counted here, too long for a repetition
  always @(posedge CLOCK) begin
    if (RESET || !VIDEO_HOLD) hold_q <= 10'h000;
    else hold_q <= hold_q + 10'h001;
  end
  sequence s_flag_then_read;
    LAST_PIXEL_FLAG ##0 $rose(READ_IN);
  endsequence
  sequence s_req_open;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  chk_valid_pulse: assert property (PIXEL_VALID |=> !PIXEL_VALID)
    else $error("pixel valid longer than one cycle");
  chk_ready_fall: assert property ($fell(FRAME_READY) |-> $past(READ_IN) || $past(FRAME_CLEAR_IN) || POWERED_DOWN)
    else $error("frame ready dropped without cause");
  chk_ready_rise: assert property ($rose(FRAME_READY) |-> !$past(EXPOSE_GATE_IN, 20))
    else $error("frame ready rose before shift ended");
  chk_flag_rise: assert property ($rose(LAST_PIXEL_FLAG) |-> $past(READ_IN))
    else $error("last pixel flag rose outside a read clock");
  chk_flag_clear: assert property (s_flag_then_read |-> ##[1:4] !LAST_PIXEL_FLAG)
    else $error("last pixel flag not cleared by read edge");
  chk_hold_start: assert property ($rose(LAST_PIXEL_FLAG) |-> ##[0:12] VIDEO_HOLD)
    else $error("video hold missing after last pixel");
  chk_hold_len: assert property (hold_q <= 10'd500)
    else $error("video hold too long");
  chk_index_range: assert property (PIXEL_VALID |-> PIXEL_INDEX < 11'd1024)
    else $error("pixel index out of range");
  chk_wb_answer: assert property (s_req_open |=> WB_ACK_O)
    else $error("bus cycle not acknowledged");
  chk_wb_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("bus ack longer than one cycle");
endmodule
bind lia_ctrl lia_chk i_lia_chk (.CLOCK, .RESET, .EXPOSE_GATE_IN, .READ_IN, .FRAME_CLEAR_IN, .FRAME_READY,
  .LAST_PIXEL_FLAG, .PIXEL_VALID, .PIXEL_INDEX, .VIDEO_HOLD, .POWERED_DOWN, .WB_CYC_I, .WB_STB_I, .WB_ACK_O);

/* verif/lia_host_model.sv */
// external controller driving the imager pins
`timescale 1ns/1ps
module lia_host_model (
  // clock and stream
  input wire clk,
  input wire pixel_valid,
  // controller pins
  output logic gate,
  output logic rd,
  output logic flush,
  output logic clear
);
  int n_pix;
  initial begin
    gate = 1'b0;
    rd = 1'b0;
    flush = 1'b0;
    clear = 1'b0;
    n_pix = 0;
  end
  always @(posedge clk) if (pixel_valid === 1'b1) n_pix <= n_pix + 1;
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic expose();
    gate <= 1'b1;
    wait_cyc(80);
    gate <= 1'b0;
    wait_cyc(50);
  endtask
  task automatic read_frame(input int nclk);
    rd <= 1'b1;
    wait_cyc(30);
    rd <= 1'b0;
    n_pix <= 0;
    wait_cyc(110);
    repeat (nclk) begin
      rd <= 1'b1;
      wait_cyc(4);
      rd <= 1'b0;
      wait_cyc(4);
    end
    wait_cyc(8);
  endtask
  // clear held wide, never in a shift
  task automatic clear_pulse();
    clear <= 1'b1;
    wait_cyc(60);
    clear <= 1'b0;
    wait_cyc(10);
  endtask
  task automatic flush_pulse();
    flush <= 1'b1;
    wait_cyc(10);
    flush <= 1'b0;
  endtask
endmodule

/* verif/tb_top.sv */
// self-checking bench for the line imager sequencer
`timescale 1ns/1ps
`include "lia_regs.vh"
module tb_top;
  logic CLOCK = 1'b0;
  logic RESET = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, wen = 1'b0, pd = 1'b0, roi = 1'b1;
  logic [3:0] adr = 4'h0;
  logic [31:0] dat = 32'h0, rdat;
  wire gate, rd, flush, clear, ready, last, valid, hold, pdn, ack;
  wire [10:0] idx;
  wire [31:0] dout;
  int err_count = 0, n_tests = 0;
  always #2 CLOCK = ~CLOCK;
  lia_ctrl i_lia_ctrl (.CLOCK(CLOCK), .RESET(RESET), .EXPOSE_GATE_IN(gate), .READ_IN(rd), .PIXEL_FLUSH_IN(flush),
    .FRAME_CLEAR_IN(clear), .POWER_DOWN_IN(pd), .CENTRE_REGION_SELECT(roi), .BIN_FACTOR_SELECT(2'h2),
    .FRAME_READY(ready), .LAST_PIXEL_FLAG(last), .PIXEL_VALID(valid), .PIXEL_INDEX(idx), .VIDEO_HOLD(hold),
    .POWERED_DOWN(pdn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(wen), .WB_ADR_I(adr), .WB_SEL_I(4'hf),
    .WB_DAT_I(dat), .WB_DAT_O(dout), .WB_ACK_O(ack));
  lia_host_model i_lia_host_model (.clk(CLOCK), .pixel_valid(valid), .gate(gate), .rd(rd), .flush(flush),
    .clear(clear));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; wen <= we; adr <= a; dat <= d;
    do begin
      @(posedge CLOCK);
      n++;
    end while (ack !== 1'b1 && n < 100);
    if (n == 100) check(0, 1);
    rdat = dout;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge CLOCK);
  endtask
  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge CLOCK);
    err_count++;
    results();
  end
  initial begin
    repeat (8) @(posedge CLOCK);
    RESET <= 1'b0;
    @(posedge CLOCK);
    check(pdn, 1);
    wb(0, 4'hc, 0); check(rdat, `LIA_ID_VALUE);
    wb(0, 4'h8, 0); check(rdat, 131);
    roi <= 1'b0;
    repeat (4) @(posedge CLOCK);
    wb(0, 4'h8, 0); check(rdat, 259);
    roi <= 1'b1;
    repeat (4) @(posedge CLOCK);
    wb(0, 4'h2, 0); check(rdat, 0);
    wb(1, 4'h0, 1); wb(0, 4'h0, 0); check(rdat, 1);
    check(pdn, 1);
    wb(1, 4'h0, 0);
    repeat (300) @(posedge CLOCK);
    check(pdn, 0);
    $display("test registers and wake done");
    i_lia_host_model.expose(); check(ready, 1);
    i_lia_host_model.read_frame(131); check(i_lia_host_model.n_pix, 128);
    check(last, 1);
    check(ready, 0);
    check(hold, 1);
    repeat (520) @(posedge CLOCK);
    check(hold, 0);
    $display("test single frame done");
    repeat (5) i_lia_host_model.expose();
    wb(0, 4'h4, 0); check(rdat[5:1], 5'h19);
    for (int i = 0; i < 4; i++) begin
      i_lia_host_model.read_frame(131); check(i_lia_host_model.n_pix, 128);
      check(ready, i < 3);
    end
    // store empty: fifth exposure was dropped
    i_lia_host_model.read_frame(131); check(i_lia_host_model.n_pix, 0);
    $display("test multi frame done");
    i_lia_host_model.flush_pulse();
    i_lia_host_model.expose(); check(ready, 0);
    i_lia_host_model.expose(); check(ready, 1);
    i_lia_host_model.clear_pulse(); check(ready, 0);
    wb(0, 4'h4, 0); check(rdat[4:2], 0);
    $display("test flush and clear done");
    pd <= 1'b1;
    repeat (10) @(posedge CLOCK);
    check(pdn, 1);
    pd <= 1'b0;
    repeat (300) @(posedge CLOCK);
    check(pdn, 0);
    $display("test power-down done");
    results();
  end
endmodule
